//--- logic/rtc_pkg.sv
/*
 * rtc_pkg: register map, field positions, reset values and divider counts
 * of the real-time clock divider with trim.
 * assumes: an 8-bit derivative register port and a 40 MHz system clock.
 */
package rtc_pkg;

   // ***************************************
   // register offsets
   // ***************************************
   localparam logic [7:0] RTC_CONTROL_OFF     = 8'h20;
   localparam logic [7:0] RTC_PERIOD_TRIM_OFF = 8'h21;
   localparam logic [7:0] RTC_EVT_STATUS_OFF  = 8'h22;
   localparam logic [7:0] RTC_EVT_MASK_OFF    = 8'h23;
   localparam logic [7:0] RTC_PORT_LINE_OFF   = 8'h24;

   // ***************************************
   // control register fields
   // ***************************************
   localparam int TICK_IRQ_EN_BIT       = 0;
   localparam int TICK_FLAG_BIT         = 1;
   localparam int TICK_SEL_BIT          = 2;
   localparam int RUN_BIT               = 3;
   localparam int SLOW_CLOCK_OUT_EN_BIT = 4;
   localparam int FACTORY_TEST_A_BIT    = 5;
   localparam int FACTORY_TEST_B_BIT    = 6;

   // event status and mask fields, port line fields
   localparam int EVT_SECOND_BIT = 0;
   localparam int EVT_MINUTE_BIT = 1;
   localparam int PORT_FF_BIT    = 0;
   localparam int PORT_LINE_BIT  = 1;

   // ***************************************
   // reset values
   // ***************************************
   localparam logic [7:0] RTC_CONTROL_RST     = 8'h00;
   localparam logic [7:0] RTC_PERIOD_TRIM_RST = 8'h00;
   localparam logic [1:0] RTC_EVT_RST         = 2'h0;
   localparam logic       PORT_FF_RST         = 1'b1;

   // ***************************************
   // timing
   // ***************************************
   localparam int          CLK_PERIOD_NS   = 25;
   localparam int          OSC_HZ          = 32768;
   localparam int          SECOND_S        = 1;
   localparam int          MINUTE_S        = 60;
   localparam int          PRESC_W         = 15;
   localparam logic [14:0] SEC_OSC_LAST    = 15'((OSC_HZ * SECOND_S) - 1);
   localparam logic [5:0]  MIN_SEC_LAST    = 6'((MINUTE_S / SECOND_S) - 1);
   localparam int          SYNC_W          = 3;

endpackage

//--- logic/rtc_divider_trim.sv
/*
 * rtc_divider_trim: oscillator gating, second/minute divider chain with
 * minute trim, tick flag and interrupt, 16 kHz clock out on a shared port line,
 * and the derivative register port.
 * assumes: 40 MHz clk_in well above the 32768 Hz oscillator pin; the core's
 * global interrupt enable and stop-mode logic sit outside and take
 * ext_irq_out and wake_out as they would the external interrupt pin.
 */
// The plain strobed port was decided locally.
// Summary of operation
// - divide oscillator into second and minute ticks
// - tick select bit picks second or minute
// - hardware or software sets flag, software clears
// - flag requests interrupt only when enabled
// - tick request ored onto external interrupt
// - enabled tick request wakes core from stop
// - chain runs regardless of core sleep state
// - run bit low stops oscillator, clears chain
// - output enable puts 16 kHz on line
// - port reads and writes still work meanwhile
// - first second after minute recounts trim clocks
// - trim lengthens only every sixtieth second tick
// - minute equals sixty seconds plus trim/16384
// - control bit seven always reads zero
// - control register at 20H, resets 00H
// - trim register at 21H, resets 00H
module rtc_divider_trim
   import rtc_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       resetn_in,
   input  wire logic [7:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   output logic      [7:0] reg_rdata_out,
   input  wire logic       osc_32k_in,
   output logic            osc_en_out,
   input  wire logic       external_irq_pin_in,
   output logic            ext_irq_out,
   output logic            wake_out,
   output logic            irq_out,
   input  wire logic       shared_port_line_in,
   output logic            shared_port_line_out,
   output logic            shared_port_line_oe_out
);
   import rtc_pkg::*;

   // ***************************************
   // decode helper
   // ***************************************
   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
      reg_hit = (addr == off);
   endfunction

   logic wr_ctrl;
   logic wr_trim;
   logic wr_status;
   logic wr_mask;
   logic wr_port;

   assign wr_ctrl   = reg_wr_in && reg_hit(reg_addr_in, RTC_CONTROL_OFF);
   assign wr_trim   = reg_wr_in && reg_hit(reg_addr_in, RTC_PERIOD_TRIM_OFF);
   assign wr_status = reg_wr_in && reg_hit(reg_addr_in, RTC_EVT_STATUS_OFF);
   assign wr_mask   = reg_wr_in && reg_hit(reg_addr_in, RTC_EVT_MASK_OFF);
   assign wr_port   = reg_wr_in && reg_hit(reg_addr_in, RTC_PORT_LINE_OFF);

   // ***************************************
   // pin synchronisers
   // ***************************************
   // bit 0 oscillator, bit 1 external interrupt, bit 2 shared line
   logic [SYNC_W-1:0] sync_a_r;
   logic [SYNC_W-1:0] sync_b_r;
   logic [SYNC_W-1:0] pin_raw;

   assign pin_raw = {shared_port_line_in, external_irq_pin_in, osc_32k_in};

   genvar gi;
   generate
      for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
         always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               sync_a_r[gi] <= 1'b0;
               sync_b_r[gi] <= 1'b0;
            end else begin
               sync_a_r[gi] <= pin_raw[gi];
               sync_b_r[gi] <= sync_a_r[gi];
            end
         end
      end
   endgenerate

   logic osc_d_r;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) osc_d_r <= 1'b0;
      else            osc_d_r <= sync_b_r[0];
   end

   // ***************************************
   // control and trim registers
   // ***************************************
   logic       tick_irq_en_r;
   logic       tick_flag_r;
   logic       tick_sel_r;
   logic       run_r;
   logic       slow_clock_out_en_r;
   logic [1:0] factory_test_r;
   logic [7:0] rtc_period_trim_r;
   logic       sec_tick;
   logic       min_tick;
   logic       tick_hw_set;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tick_irq_en_r       <= RTC_CONTROL_RST[TICK_IRQ_EN_BIT];
         tick_sel_r          <= RTC_CONTROL_RST[TICK_SEL_BIT];
         run_r               <= RTC_CONTROL_RST[RUN_BIT];
         slow_clock_out_en_r <= RTC_CONTROL_RST[SLOW_CLOCK_OUT_EN_BIT];
         factory_test_r      <= RTC_CONTROL_RST[FACTORY_TEST_B_BIT:FACTORY_TEST_A_BIT];
      end else if (wr_ctrl) begin
         tick_irq_en_r       <= reg_wdata_in[TICK_IRQ_EN_BIT];
         tick_sel_r          <= reg_wdata_in[TICK_SEL_BIT];
         run_r               <= reg_wdata_in[RUN_BIT];
         slow_clock_out_en_r <= reg_wdata_in[SLOW_CLOCK_OUT_EN_BIT];
         // test bits are held for read-back only; they steer nothing here
         factory_test_r      <= reg_wdata_in[FACTORY_TEST_B_BIT:FACTORY_TEST_A_BIT];
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in)   rtc_period_trim_r <= RTC_PERIOD_TRIM_RST;
      else if (wr_trim) rtc_period_trim_r <= reg_wdata_in;
   end

   // the selected tick is the chain overflow on an oscillator rising edge
   assign tick_hw_set = tick_sel_r ? sec_tick : min_tick;

   // a hardware set in the same cycle as a software clear wins
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in)       tick_flag_r <= RTC_CONTROL_RST[TICK_FLAG_BIT];
      else if (tick_hw_set) tick_flag_r <= 1'b1;
      else if (wr_ctrl)     tick_flag_r <= reg_wdata_in[TICK_FLAG_BIT];
   end

   // ***************************************
   // oscillator and divider chain
   // ***************************************
   logic                osc_edge;
   logic [PRESC_W-1:0]  presc_r;
   logic [5:0]          sec_cnt_r;
   logic [7:0]          hold_cnt_r;
   logic                hold_now;

   // oscillator is gated off by the run bit, so no edge reaches the chain
   assign osc_en_out = run_r;
   assign osc_edge   = run_r && sync_b_r[0] && !osc_d_r;

   // repeat a 16 kHz clock while trim remains in the first second
   assign hold_now = (hold_cnt_r != 8'h00) && (sec_cnt_r == 6'h00) && presc_r[0];
   assign sec_tick = osc_edge && !hold_now && (presc_r == SEC_OSC_LAST);
   assign min_tick = sec_tick && (sec_cnt_r == MIN_SEC_LAST);

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         presc_r <= '0;
      end else if (!run_r) begin
         presc_r <= '0;
      end else if (osc_edge) begin
         if (hold_now) presc_r <= {presc_r[PRESC_W-1:1], 1'b0};
         else          presc_r <= presc_r + 15'h0001;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in)    sec_cnt_r <= 6'h00;
      else if (!run_r)   sec_cnt_r <= 6'h00;
      else if (min_tick) sec_cnt_r <= 6'h00;
      else if (sec_tick) sec_cnt_r <= sec_cnt_r + 6'h01;
   end

   // trim is loaded once per minute, so only one second in sixty stretches
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in)                hold_cnt_r <= 8'h00;
      else if (!run_r)               hold_cnt_r <= 8'h00;
      else if (min_tick)             hold_cnt_r <= rtc_period_trim_r;
      else if (osc_edge && hold_now) hold_cnt_r <= hold_cnt_r - 8'h01;
   end

   // ***************************************
   // tick interrupt onto the external path
   // ***************************************
   logic tick_req;

   assign tick_req    = tick_flag_r && tick_irq_en_r;
   assign ext_irq_out = tick_req || sync_b_r[1];
   // stop-mode wake uses the same merged request as the external pin
   assign wake_out    = ext_irq_out;

   // ***************************************
   // event status, mask and interrupt
   // ***************************************
   logic [1:0] evt_status_r;
   logic [1:0] evt_mask_r;
   logic [1:0] evt_set;

   assign evt_set = {min_tick, sec_tick};

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in)     evt_status_r <= RTC_EVT_RST;
      else if (wr_status) evt_status_r <= (evt_status_r & ~reg_wdata_in[1:0]) | evt_set;
      else                evt_status_r <= evt_status_r | evt_set;
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in)   evt_mask_r <= RTC_EVT_RST;
      else if (wr_mask) evt_mask_r <= reg_wdata_in[1:0];
   end

   assign irq_out = |(evt_status_r & evt_mask_r);

   // ***************************************
   // shared port line
   // ***************************************
   logic port_ff_r;
   logic line_level;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in)   port_ff_r <= PORT_FF_RST;
      else if (wr_port) port_ff_r <= reg_wdata_in[PORT_FF_BIT];
   end

   // open drain with pull-up: clock out bypasses the port flip-flop, so a flip-flop left low cannot clamp the clock
   assign line_level              = slow_clock_out_en_r ? presc_r[0] : port_ff_r;
   assign shared_port_line_out    = 1'b0;
   assign shared_port_line_oe_out = !line_level;

   // ***************************************
   // read port
   // ***************************************
   logic [7:0] rd_mux;

   always_comb begin
      rd_mux = 8'h00;
      if (reg_hit(reg_addr_in, RTC_CONTROL_OFF)) begin
         rd_mux = {1'b0, factory_test_r, slow_clock_out_en_r, run_r,
                   tick_sel_r, tick_flag_r, tick_irq_en_r};
      end else if (reg_hit(reg_addr_in, RTC_PERIOD_TRIM_OFF)) begin
         rd_mux = rtc_period_trim_r;
      end else if (reg_hit(reg_addr_in, RTC_EVT_STATUS_OFF)) begin
         rd_mux = {6'h00, evt_status_r};
      end else if (reg_hit(reg_addr_in, RTC_EVT_MASK_OFF)) begin
         rd_mux = {6'h00, evt_mask_r};
      end else if (reg_hit(reg_addr_in, RTC_PORT_LINE_OFF)) begin
         rd_mux = {6'h00, sync_b_r[2], port_ff_r};
      end
   end

   // data only in the cycle after the strobe; zero otherwise
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in)     reg_rdata_out <= 8'h00;
      else if (reg_rd_in) reg_rdata_out <= rd_mux;
      else                reg_rdata_out <= 8'h00;
   end

   // ***************************************
   // checks
   // ***************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   sequence s_hold_step;
      osc_edge && hold_now;
   endsequence

   sequence s_upper_kept;
      (presc_r[PRESC_W-1:1] == $past(presc_r[PRESC_W-1:1])) && !presc_r[0];
   endsequence

   chk_sec_flag_set: assert property (tick_sel_r && sec_tick |=> tick_flag_r)
      else $error("second tick did not set flag");

   chk_min_flag_set: assert property (!tick_sel_r && min_tick |=> tick_flag_r)
      else $error("minute tick did not set flag");

   chk_flag_no_drop: assert property (tick_flag_r && !wr_ctrl |=> tick_flag_r)
      else $error("tick flag cleared without a write");

   chk_irq_gated: assert property (!tick_irq_en_r && !sync_b_r[1] |-> !ext_irq_out)
      else $error("disabled tick flag requested interrupt");

   chk_wake_req: assert property (tick_flag_r && tick_irq_en_r |-> wake_out && ext_irq_out)
      else $error("enabled tick did not wake core");

   chk_stop_clear: assert property (!run_r |-> !osc_en_out ##1 presc_r == '0 && sec_cnt_r == 6'h00)
      else $error("chain not held while stopped");

   chk_clk_out_sel: assert property (slow_clock_out_en_r |-> shared_port_line_oe_out == !presc_r[0])
      else $error("16 kHz clock not on shared line");

   chk_trim_repeat: assert property (s_hold_step |=> s_upper_kept)
      else $error("trim step advanced the chain");

   chk_sec_wrap: assert property (sec_tick |=> presc_r == '0 ##1 presc_r[PRESC_W-1:1] == '0)
      else $error("second tick not at chain overflow");

   chk_ctrl_bit7: assert property (reg_rd_in && reg_hit(reg_addr_in, RTC_CONTROL_OFF) |=> !reg_rdata_out[7])
      else $error("control bit 7 read as one");

   // ***************************************
   // checks: divider and trim
   // ***************************************
   // trim is captured at the minute edge; a write in that same cycle lands a minute late
   sequence s_min_edge;
      osc_edge && !hold_now && (presc_r == SEC_OSC_LAST) && (sec_cnt_r == MIN_SEC_LAST);
   endsequence

   sequence s_trim_loaded;
      (hold_cnt_r == $past(rtc_period_trim_r)) && (sec_cnt_r == 6'h00);
   endsequence

   chk_trim_load: assert property (s_min_edge |=> s_trim_loaded)
      else $error("trim not loaded at minute tick");

   chk_trim_count: assert property (s_hold_step |=> hold_cnt_r == $past(hold_cnt_r) - 8'h01)
      else $error("trim countdown did not step");

   chk_sec_count: assert property (sec_tick && sec_cnt_r != MIN_SEC_LAST
                                   |=> sec_cnt_r == $past(sec_cnt_r) + 6'h01)
      else $error("second count did not advance");

   chk_min_wrap: assert property (min_tick |=> sec_cnt_r == 6'h00)
      else $error("second count did not wrap at minute");

   // ***************************************
   // checks: flag, requests and events
   // ***************************************
   chk_flag_sw_set: assert property (wr_ctrl && reg_wdata_in[TICK_FLAG_BIT] |=> tick_flag_r)
      else $error("software could not set tick flag");

   chk_flag_sw_clr: assert property (wr_ctrl && !reg_wdata_in[TICK_FLAG_BIT]
                                     && !tick_hw_set |=> !tick_flag_r)
      else $error("software could not clear tick flag");

   chk_pin_merge: assert property (sync_b_r[1] |-> ext_irq_out && wake_out)
      else $error("external pin request lost");

   chk_evt_irq: assert property (sec_tick && evt_mask_r[EVT_SECOND_BIT] && !wr_mask |=> irq_out)
      else $error("unmasked second event gave no interrupt");

   chk_evt_min_irq: assert property (min_tick && evt_mask_r[EVT_MINUTE_BIT] && !wr_mask |=> irq_out)
      else $error("unmasked minute event gave no interrupt");

   chk_evt_sticky: assert property (evt_status_r[EVT_SECOND_BIT] && !wr_status |=> evt_status_r[EVT_SECOND_BIT])
      else $error("second event dropped without a write");

   // ***************************************
   // checks: register port and shared line
   // ***************************************
   // read data is a one-cycle pulse, so a late sampler sees zero rather than stale data
   chk_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
      else $error("read data outside a read cycle");

   chk_trim_rd: assert property (reg_rd_in && reg_hit(reg_addr_in, RTC_PERIOD_TRIM_OFF)
                                 |=> reg_rdata_out == $past(rtc_period_trim_r))
      else $error("trim register read back wrong");

   chk_port_rd: assert property (reg_rd_in && reg_hit(reg_addr_in, RTC_PORT_LINE_OFF)
                                 |=> reg_rdata_out[PORT_FF_BIT] == $past(port_ff_r))
      else $error("port flip-flop read back wrong");

   chk_line_port: assert property (!slow_clock_out_en_r |-> shared_port_line_oe_out == !port_ff_r)
      else $error("port flip-flop not on shared line");

endmodule

//--- bench/rtc_divider_trim_test.sv
/*
 * rtc_divider_trim_test: self-checking bench for the rtc divider with trim.
 * assumes: rtc_pkg and rtc_divider_trim compiled first; the shared line is
 * open drain with a pull-up, modelled here from the design's enable.
 */
module rtc_divider_trim_test;
   timeunit 1ns;
   timeprecision 1ps;
   import rtc_pkg::*;

   // ***************************************
   // signals
   // ***************************************
   logic       clk_in              = 1'b0;
   logic       resetn_in           = 1'b0;
   logic [7:0] reg_addr_in         = 8'h00;
   logic [7:0] reg_wdata_in        = 8'h00;
   logic       reg_wr_in           = 1'b0;
   logic       reg_rd_in           = 1'b0;
   logic       osc_32k_in          = 1'b0;
   logic       external_irq_pin_in = 1'b0;
   wire        shared_port_line_in;
   logic [7:0] reg_rdata_out;
   logic       osc_en_out;
   logic       ext_irq_out;
   logic       wake_out;
   logic       irq_out;
   logic       shared_port_line_out;
   logic       shared_port_line_oe_out;
   logic       rd_seen = 1'b0;
   logic       last_oe = 1'b0;
   logic [7:0] exp_q[$];
   string      name_q[$];
   int         n_mismatch  = 0;
   int         check_count = 0;
   int         toggles     = 0;
   int         base_toggles;
   logic [7:0] trim_val;

   // pull-up wins whenever nobody pulls low
   assign shared_port_line_in = shared_port_line_oe_out ? shared_port_line_out : 1'b1;

   always #12.5 clk_in = ~clk_in;

   rtc_divider_trim i_rtc_divider_trim (
      .clk_in                  (clk_in),
      .resetn_in               (resetn_in),
      .reg_addr_in             (reg_addr_in),
      .reg_wdata_in            (reg_wdata_in),
      .reg_wr_in               (reg_wr_in),
      .reg_rd_in               (reg_rd_in),
      .reg_rdata_out           (reg_rdata_out),
      .osc_32k_in              (osc_32k_in),
      .osc_en_out              (osc_en_out),
      .external_irq_pin_in     (external_irq_pin_in),
      .ext_irq_out             (ext_irq_out),
      .wake_out                (wake_out),
      .irq_out                 (irq_out),
      .shared_port_line_in     (shared_port_line_in),
      .shared_port_line_out    (shared_port_line_out),
      .shared_port_line_oe_out (shared_port_line_oe_out)
   );

   // ***************************************
   // checking and bus tasks
   // ***************************************
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge clk_in);
      reg_wr_in    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      exp_q.push_back(e);
      name_q.push_back(what);
      @(posedge clk_in);
      reg_rd_in   <= 1'b0;
   endtask

   // one oscillator cycle every two clocks keeps a second near 65k clocks
   task automatic osc(input int n);
      repeat (n) begin
         @(posedge clk_in);
         osc_32k_in <= 1'b1;
         @(posedge clk_in);
         osc_32k_in <= 1'b0;
      end
   endtask

   task automatic flags(input logic [3:0] e);
      @(negedge clk_in);
      check("line_out osc_en ext_irq wake irq",
            {3'h0, shared_port_line_out, osc_en_out, ext_irq_out, wake_out, irq_out}, {4'h0, e});
   endtask

   task automatic wait_ext(input logic v);
      int i;
      @(negedge clk_in);
      for (i = 0; i < 64 && ext_irq_out !== v; i++) @(negedge clk_in);
      check("ext_irq", {7'h00, ext_irq_out}, {7'h00, v});
      if (ext_irq_out !== v) stop_test();
   endtask

   // ***************************************
   // monitors
   // ***************************************
   always @(posedge clk_in) begin
      rd_seen <= reg_rd_in;
      last_oe <= shared_port_line_oe_out;
      if (last_oe != shared_port_line_oe_out) toggles <= toggles + 1;
   end

   // read data stand only in the cycle after the strobe
   always @(negedge clk_in) begin
      if (rd_seen && exp_q.size() > 0) check(name_q.pop_front(), reg_rdata_out, exp_q.pop_front());
   end

   initial begin
      #2000000;
      n_mismatch++;
      stop_test();
   end

   // ***************************************
   // main sequence
   // ***************************************
   initial begin
      void'($urandom(32'h5573));
      repeat (5) @(posedge clk_in);
      resetn_in <= 1'b1;
      flags(4'h0);
      rd(RTC_CONTROL_OFF, 8'h00, "control");
      rd(RTC_PERIOD_TRIM_OFF, 8'h00, "trim");
      rd(RTC_EVT_STATUS_OFF, 8'h00, "status");
      rd(RTC_EVT_MASK_OFF, 8'h00, "mask");
      rd(RTC_PORT_LINE_OFF, 8'h03, "port");
      rd(8'h25, 8'h00, "unmapped");
      trim_val = 8'($urandom());
      wr(RTC_PERIOD_TRIM_OFF, trim_val);
      rd(RTC_PERIOD_TRIM_OFF, trim_val, "trim");
      wr(RTC_PERIOD_TRIM_OFF, 8'h00);
      // test bits written zero, port flip-flop left high under clock out
      wr(RTC_CONTROL_OFF, 8'h9B);
      flags(4'hE);
      rd(RTC_CONTROL_OFF, 8'h1B, "control");
      base_toggles = toggles;
      osc(8);
      repeat (8) @(posedge clk_in);
      check("clock out toggles", 8'(toggles - base_toggles), 8'h08);
      wr(RTC_CONTROL_OFF, 8'h0A);
      flags(4'h8);
      wr(RTC_CONTROL_OFF, 8'h09);
      flags(4'h8);
      @(posedge clk_in);
      external_irq_pin_in <= 1'b1;
      wait_ext(1'b1);
      flags(4'hE);
      @(posedge clk_in);
      external_irq_pin_in <= 1'b0;
      wait_ext(1'b0);
      wr(RTC_CONTROL_OFF, 8'h08);
      wr(RTC_PORT_LINE_OFF, 8'h00);
      repeat (4) @(posedge clk_in);
      rd(RTC_PORT_LINE_OFF, 8'h00, "port");
      wr(RTC_PORT_LINE_OFF, 8'h01);
      repeat (4) @(posedge clk_in);
      rd(RTC_PORT_LINE_OFF, 8'h03, "port");
      // clock out on with the divider parked even: line low, flip-flop still reads high
      wr(RTC_CONTROL_OFF, 8'h18);
      repeat (4) @(posedge clk_in);
      rd(RTC_PORT_LINE_OFF, 8'h01, "port");
      // partial count must be discarded by the stop
      osc(100);
      wr(RTC_CONTROL_OFF, 8'h00);
      flags(4'h0);
      wr(RTC_EVT_MASK_OFF, 8'h01);
      wr(RTC_CONTROL_OFF, 8'h0D);
      osc(32760);
      rd(RTC_CONTROL_OFF, 8'h0D, "control");
      osc(16);
      wait_ext(1'b1);
      rd(RTC_CONTROL_OFF, 8'h0F, "control");
      rd(RTC_EVT_STATUS_OFF, 8'h01, "status");
      flags(4'hF);
      wr(RTC_EVT_MASK_OFF, 8'h00);
      flags(4'hE);
      wr(RTC_EVT_MASK_OFF, 8'h01);
      wr(RTC_EVT_STATUS_OFF, 8'h01);
      flags(4'hE);
      rd(RTC_EVT_STATUS_OFF, 8'h00, "status");
      wr(RTC_CONTROL_OFF, 8'h0D);
      flags(4'h8);
      // a reset in mid-run must bring the control, trim and mask registers back
      wr(RTC_PERIOD_TRIM_OFF, trim_val);
      @(posedge clk_in);
      resetn_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      resetn_in <= 1'b1;
      flags(4'h0);
      rd(RTC_CONTROL_OFF, 8'h00, "control");
      rd(RTC_PERIOD_TRIM_OFF, 8'h00, "trim");
      rd(RTC_EVT_MASK_OFF, 8'h00, "mask");
      repeat (3) @(posedge clk_in);
      stop_test();
   end

endmodule
